// ===== logic/plsl_consts.vh
// Purpose: shared constants for the port indicator and strap block
// Assumes: 32-bit APB, core clock at 20 MHz
// Notes:   definitions only, no logic
`ifndef PLSL_CONSTS_VH
`define PLSL_CONSTS_VH

// clock and blink timing
`define PLSL_CLK_HZ          20000000
`define PLSL_BLINK_MS        30
// 30 ms of 20 MHz cycles, sized to the divider so no bits are dropped
`define PLSL_BLINK_CYCLES    20'd600000
`define PLSL_BLINK_W         20

// port count
`define PLSL_PORTS           5

// register byte offsets
`define PLSL_REG_STRAP       12'h000
`define PLSL_REG_CFGMEM      12'h004
`define PLSL_REG_LEDCTL      12'h008
`define PLSL_REG_PORTSTAT    12'h00c

// strap register fields
`define PLSL_STRAP_BP        0
`define PLSL_STRAP_AN        1
`define PLSL_STRAP_XOV       2
`define PLSL_STRAP_COLOUR    3
`define PLSL_STRAP_ADDR_LO   4
`define PLSL_STRAP_ADDR_HI   5
`define PLSL_STRAP_VALID     8

// config memory register fields
`define PLSL_CFG_SEL         0
`define PLSL_CFG_CLK         1
`define PLSL_CFG_DOUT        2
`define PLSL_CFG_DIN         8

// led control fields
`define PLSL_LED_OFF         0

// port status field bases
`define PLSL_PS_LINK         0
`define PLSL_PS_FDX          8
`define PLSL_PS_SPD          16

// strap defaults before the first capture
`define PLSL_DEF_BP          1'b1
`define PLSL_DEF_AN          1'b1
`define PLSL_DEF_XOV         1'b0
`define PLSL_DEF_COLOUR      1'b0
`define PLSL_DEF_ADDR_HI     1'b0
`define PLSL_DEF_ADDR_LO     1'b0

`endif

// ===== logic/plsl_blink.v
// Purpose: shared blink square wave for all port indicators
// Assumes: one clock, asynchronous active-low reset
// Notes:   half period set by a parameter so simulation can shorten it
`timescale 1ns/1ps
`default_nettype none
`include "plsl_consts.vh"

module plsl_blink #(
    parameter [`PLSL_BLINK_W-1:0] HALF_CYCLES = `PLSL_BLINK_CYCLES
) (
    input  wire                     pclk,
    input  wire                     presetn,
    output reg                      blink
);

    reg [`PLSL_BLINK_W-1:0] count;   // cycles into the current half period

    // free-running divider; one toggle per half period
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= {`PLSL_BLINK_W{1'b0}};
            blink <= 1'b0;
        end else if (count >= HALF_CYCLES - 1'b1) begin
            count <= {`PLSL_BLINK_W{1'b0}};
            blink <= ~blink;
        end else begin
            count <= count + 1'b1;
        end
    end

endmodule // plsl_blink
`default_nettype wire

// ===== logic/plsl_port_led.v
// Purpose: indicator levels for one switch port
// Assumes: status inputs synchronous to pclk
// Notes:   all three lamps are active low
`timescale 1ns/1ps
`default_nettype none

module plsl_port_led (
    input  wire                     pclk,
    input  wire                     presetn,
    input  wire                     blink,
    input  wire                     leds_off,
    input  wire                     link_up,
    input  wire                     activity,
    input  wire                     full_duplex,
    input  wire                     collision,
    input  wire                     speed_100,
    output reg                      link_led,
    output reg                      dup_led,
    output reg                      spd_led
);

    // registered lamp levels; reset shows every lamp dark
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_led <= 1'b1;
            dup_led  <= 1'b1;
            spd_led  <= 1'b1;
        end else if (leds_off) begin
            // lamp test off: everything dark
            link_led <= 1'b1;
            dup_led  <= 1'b1;
            spd_led  <= 1'b1;
        end else begin
            if (!link_up)
                link_led <= 1'b1;
            else if (activity)
                link_led <= blink;
            else
                link_led <= 1'b0;
            // collision blink takes priority over duplex level
            if (collision)
                dup_led <= blink;
            else
                dup_led <= ~full_duplex;
            spd_led <= ~speed_100;
        end
    end

endmodule // plsl_port_led
`default_nettype wire

// ===== logic/plsl_top.v
// Purpose: port indicator drive, power-on strap capture and config memory pin control
// Assumes: pclk at 20 MHz; status and pin inputs synchronous to pclk
// Notes:   config memory protocol is bit-banged by software through a register
`timescale 1ns/1ps
`default_nettype none
`include "plsl_consts.vh"

module plsl_top #(
    parameter [`PLSL_BLINK_W-1:0] BLINK_HALF_CYCLES = `PLSL_BLINK_CYCLES
) (
    // apb slave
    input  wire                     pclk,
    input  wire                     presetn,
    input  wire                     psel,
    input  wire                     penable,
    input  wire                     pwrite,
    input  wire [11:0]              paddr,
    input  wire [31:0]              pwdata,
    output wire                     pready,
    output reg  [31:0]              prdata,
    output wire                     pslverr,
    // power-on reset input
    input  wire                     rc_reset_input,
    // per-port status from the switch core
    input  wire [4:0]               port_link_up,
    input  wire [4:0]               port_activity,
    input  wire [4:0]               port_full_duplex,
    input  wire [4:0]               port_collision,
    input  wire [4:0]               port_speed_100,
    // indicator pins
    output wire [4:0]               link_activity_led,
    output wire [4:0]               duplex_collision_led_o,
    output wire [4:0]               duplex_collision_led_oe,
    input  wire [4:0]               duplex_collision_led_i,
    output wire [4:0]               port_speed_led,
    // low address strap pin
    input  wire                     transmit_enable_pin,
    // serial configuration memory pins
    input  wire                     cfg_mem_serial_in,
    output wire                     cfg_mem_select_o,
    output wire                     cfg_mem_select_oe,
    output wire                     cfg_mem_serial_clock_o,
    output wire                     cfg_mem_serial_clock_oe,
    input  wire                     cfg_mem_serial_clock_i,
    output wire                     cfg_mem_serial_out_o,
    output wire                     cfg_mem_serial_out_oe,
    input  wire                     cfg_mem_serial_out_i,
    // captured strap settings for the switch core
    output reg                      backpressure_strap,
    output reg                      autoneg_strap,
    output reg                      crossover_strap,
    output reg                      indicator_colour_strap,
    output reg                      chip_address_strap_high,
    output reg                      chip_address_strap_low,
    output reg                      strap_valid,
    output wire                     reset_n_pin
);

    // power-on reset sequencing

    reg                             rc_meta;     // first synchroniser stage
    reg                             rc_sync;     // second stage, safe to use
    reg                             por_active;  // high until rc input released

    // two-flop synchroniser on the slow rc input; the rc edge is far
    // slower than pclk, so metastability is the only hazard
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rc_meta <= 1'b0;
            rc_sync <= 1'b0;
        end else begin
            rc_meta <= rc_reset_input;
            rc_sync <= rc_meta;
        end
    end

    // internal power-on reset: held from presetn until rc input goes high
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            por_active <= 1'b1;
        else if (rc_sync)
            por_active <= 1'b0;
    end

    // capture happens on the one cycle when the power-on reset lets go
    wire strap_capture = por_active & rc_sync;

    // inverted copy of the internal power-on reset for the rest of the chip
    assign reset_n_pin = ~por_active;

    // strap capture

    // pins float during reset so pulls set the level; values are caught
    // in a clocked process at release, never loaded by the async reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            backpressure_strap      <= `PLSL_DEF_BP;
            autoneg_strap           <= `PLSL_DEF_AN;
            crossover_strap         <= `PLSL_DEF_XOV;
            indicator_colour_strap  <= `PLSL_DEF_COLOUR;
            chip_address_strap_high <= `PLSL_DEF_ADDR_HI;
            chip_address_strap_low  <= `PLSL_DEF_ADDR_LO;
            strap_valid             <= 1'b0;
        end else if (strap_capture) begin
            backpressure_strap      <= duplex_collision_led_i[2];
            chip_address_strap_high <= duplex_collision_led_i[1];
            chip_address_strap_low  <= transmit_enable_pin;
            autoneg_strap           <= duplex_collision_led_i[0];
            crossover_strap         <= cfg_mem_serial_clock_i;
            indicator_colour_strap  <= cfg_mem_serial_out_i;
            strap_valid             <= 1'b1;
        end
    end

    // software registers

    reg                             cfg_sel;     // memory chip-select level
    reg                             cfg_clk;     // memory serial clock level
    reg                             cfg_dout;    // memory serial data level
    reg                             leds_off;    // lamp blank control

    wire setup_phase = psel & ~penable;          // address phase of apb
    wire wr_access   = psel & penable & pwrite;  // write takes effect here

    // decode of mapped offsets; word aligned only
    wire hit_strap = (paddr == `PLSL_REG_STRAP);
    wire hit_cfg   = (paddr == `PLSL_REG_CFGMEM);
    wire hit_led   = (paddr == `PLSL_REG_LEDCTL);
    wire hit_stat  = (paddr == `PLSL_REG_PORTSTAT);
    wire hit_any   = hit_strap | hit_cfg | hit_led | hit_stat;

    // zero wait states; unmapped offsets answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit_any;

    // writable controls; read-only offsets ignore writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_sel  <= 1'b0;
            cfg_clk  <= 1'b0;
            cfg_dout <= 1'b0;
            leds_off <= 1'b0;
        end else if (wr_access) begin
            if (hit_cfg) begin
                cfg_sel  <= pwdata[`PLSL_CFG_SEL];
                cfg_clk  <= pwdata[`PLSL_CFG_CLK];
                cfg_dout <= pwdata[`PLSL_CFG_DOUT];
            end
            if (hit_led)
                leds_off <= pwdata[`PLSL_LED_OFF];
        end
    end

    // read mux, combinational, registered below
    reg [31:0] next_prdata;
    always @* begin
        next_prdata = 32'h0000_0000;
        if (hit_strap) begin
            next_prdata[`PLSL_STRAP_BP]      = backpressure_strap;
            next_prdata[`PLSL_STRAP_AN]      = autoneg_strap;
            next_prdata[`PLSL_STRAP_XOV]     = crossover_strap;
            next_prdata[`PLSL_STRAP_COLOUR]  = indicator_colour_strap;
            next_prdata[`PLSL_STRAP_ADDR_LO] = chip_address_strap_low;
            next_prdata[`PLSL_STRAP_ADDR_HI] = chip_address_strap_high;
            next_prdata[`PLSL_STRAP_VALID]   = strap_valid;
        end else if (hit_cfg) begin
            next_prdata[`PLSL_CFG_SEL]  = cfg_sel;
            next_prdata[`PLSL_CFG_CLK]  = cfg_clk;
            next_prdata[`PLSL_CFG_DOUT] = cfg_dout;
            next_prdata[`PLSL_CFG_DIN]  = cfg_mem_serial_in;
        end else if (hit_led) begin
            next_prdata[`PLSL_LED_OFF] = leds_off;
        end else if (hit_stat) begin
            next_prdata[`PLSL_PS_LINK+4:`PLSL_PS_LINK] = port_link_up;
            next_prdata[`PLSL_PS_FDX+4:`PLSL_PS_FDX]   = port_full_duplex;
            next_prdata[`PLSL_PS_SPD+4:`PLSL_PS_SPD]   = port_speed_100;
        end
    end

    // read data captured in the setup cycle so it is steady in access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (setup_phase)
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
    end

    // config memory pin drive

    // all three pins float during power-on reset so straps can be read;
    // afterwards they follow the software levels
    assign cfg_mem_select_oe       = ~por_active;
    assign cfg_mem_serial_clock_oe = ~por_active;
    assign cfg_mem_serial_out_oe   = ~por_active;
    assign cfg_mem_select_o        = cfg_sel;
    assign cfg_mem_serial_clock_o  = cfg_clk;
    assign cfg_mem_serial_out_o    = cfg_dout;

    // indicators

    wire blink;  // shared square wave for every port

    plsl_blink #(
        .HALF_CYCLES (BLINK_HALF_CYCLES)
    ) u_blink (
        .pclk    (pclk),
        .presetn (presetn),
        .blink   (blink)
    );

    // duplex lamps share pins with straps, so they float during reset too;
    // a lamp glitch at power-up is the price of the shared pin
    assign duplex_collision_led_oe = {`PLSL_PORTS{~por_active}};

    genvar gi;
    generate
        for (gi = 0; gi < `PLSL_PORTS; gi = gi + 1) begin : g_port
            plsl_port_led u_led (
                .pclk        (pclk),
                .presetn     (presetn),
                .blink       (blink),
                .leds_off    (leds_off),
                .link_up     (port_link_up[gi]),
                .activity    (port_activity[gi]),
                .full_duplex (port_full_duplex[gi]),
                .collision   (port_collision[gi]),
                .speed_100   (port_speed_100[gi]),
                .link_led    (link_activity_led[gi]),
                .dup_led     (duplex_collision_led_o[gi]),
                .spd_led     (port_speed_led[gi])
            );
        end
    endgenerate

endmodule // plsl_top
`default_nettype wire

// ===== sim/plsl_top_props.sv
// Purpose: pin-level checks on plsl_top
// Assumes: one clock domain, presetn asynchronous active low
// Notes:   checks that expect a lamp lit are masked around the software lamps-off control
`timescale 1ns/1ps
`default_nettype none
module plsl_top_props #(
    parameter [19:0] BLINK_HALF_CYCLES = 20'h8
) (
    input wire logic        pclk, presetn, psel, penable, pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [4:0]  port_link_up, port_activity, port_full_duplex, port_collision, port_speed_100,
    input wire logic [4:0]  link_activity_led, duplex_collision_led_o, duplex_collision_led_i, port_speed_led,
    input wire logic        transmit_enable_pin, cfg_mem_select_oe, cfg_mem_serial_clock_oe, cfg_mem_serial_out_oe,
    input wire logic        backpressure_strap, chip_address_strap_high, chip_address_strap_low, strap_valid,
    input wire logic        reset_n_pin
);
    logic        off, off_d; // lamps-off shadow and its last value
    logic [4:0]  m;          // lamps free of the override
    logic        prev0;      // last level of port 0 link lamp
    logic [19:0] still;      // cycles port 0 lamp held during traffic
    // mask both edges of a lamps-off change, as its latency is the design's choice
    assign m = ~{5{off | off_d}};
    // shadow the lamps-off bit and count how long the traffic lamp holds still
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            off <= 1'b0;
            off_d <= 1'b0;
            prev0 <= 1'b1;
            still <= 20'h0;
        end else begin
            if (psel && penable && pwrite && paddr == 12'h008)
                off <= pwdata[0];
            off_d <= off;
            prev0 <= link_activity_led[0];
            still <= (port_link_up[0] && port_activity[0] && m[0] && prev0 == link_activity_led[0])
                     ? still + 20'h1 : 20'h0;
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_link_dark: assert property ((link_activity_led | $past(port_link_up)) == 5'h1f)
        else $error("link lamp lit without link");
    a_link_idle: assert property ($past(presetn) |-> (link_activity_led & $past(port_link_up & ~port_activity) & m) == 5'h0)
        else $error("idle link lamp not lit");
    a_blink_rate: assert property (still <= BLINK_HALF_CYCLES + 20'h1)
        else $error("traffic lamp not blinking");
    a_dup_level: assert property ($past(presetn) |->
        (duplex_collision_led_o & $past(port_full_duplex & ~port_collision) & m) == 5'h0
        && (~duplex_collision_led_o & $past(~port_full_duplex & ~port_collision)) == 5'h0)
        else $error("duplex lamp level wrong");
    a_speed_level: assert property ($past(presetn) |-> ((port_speed_led ^ ~$past(port_speed_100)) & m) == 5'h0)
        else $error("speed lamp level wrong");
    a_pins_float: assert property (!reset_n_pin |-> !(cfg_mem_select_oe || cfg_mem_serial_clock_oe || cfg_mem_serial_out_oe))
        else $error("memory pins driven in reset");
    a_pins_drive: assert property ($rose(strap_valid) |-> cfg_mem_select_oe && cfg_mem_serial_clock_oe && cfg_mem_serial_out_oe && reset_n_pin)
        else $error("memory pins not driven after reset");
    a_bp_capture: assert property ($rose(strap_valid) |-> backpressure_strap == $past(duplex_collision_led_i[2]))
        else $error("back-pressure strap wrong");
    a_addr_capture: assert property ($rose(strap_valid) |-> chip_address_strap_high == $past(duplex_collision_led_i[1])
        && chip_address_strap_low == $past(transmit_enable_pin))
        else $error("address strap wrong");
    a_strap_hold: assert property (strap_valid |=> strap_valid && $stable({backpressure_strap, chip_address_strap_high}))
        else $error("straps moved after capture");
endmodule // plsl_top_props
bind plsl_top plsl_top_props #(.BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)) u_props (.*);
`default_nettype wire

// ===== sim/plsl_far_side.sv
// Purpose: strap resistors and serial configuration memory
// Assumes: memory clock is bit-banged slowly against pclk
// Notes:   pins 3 and 4 carry no strap, so a released pin shows the inverse
`timescale 1ns/1ps
`default_nettype none
module plsl_far_side #(
    parameter [15:0] PATTERN = 16'hb38d
) (
    input wire logic       pclk,
    input wire logic [4:0] strap_bits, // an, addr high, bp, crossover, colour
    input wire logic [4:0] dup_o, dup_oe,
    input wire logic       sel_o, sel_oe, clk_o, clk_oe, dout_o, dout_oe,
    output logic [4:0]     dup_i,
    output logic           clk_i, dout_i, din
);
    logic [15:0] shreg; // read data, msb first
    logic        clk_q; // last memory clock level
    // released pins settle to their strap resistor
    assign dup_i = (dup_oe & dup_o) | (~dup_oe & {~dup_o[4:3], strap_bits[2:0]});
    assign clk_i = clk_oe ? clk_o : strap_bits[3];
    assign dout_i = dout_oe ? dout_o : strap_bits[4];
    // unselected memory floats, the pull-up wins
    assign din = (sel_oe && sel_o) ? shreg[15] : 1'b1;
    // advance one bit per rising memory clock while selected
    always_ff @(posedge pclk) begin
        clk_q <= clk_o;
        if (!(sel_oe && sel_o))
            shreg <= PATTERN;
        else if (clk_o && !clk_q)
            shreg <= {shreg[14:0], 1'b0};
    end
endmodule // plsl_far_side
`default_nettype wire

// ===== sim/tb_top.sv
// Purpose: self-checking bench for plsl_top
// Assumes: 50 ns clock, shortened blink period
// Notes:   one idle cycle between bus transfers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam [19:0] HALF = 20'h8;      // shortened blink half period
    localparam [15:0] PAT  = 16'hb38d;   // memory contents
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rc_reset_input, transmit_enable_pin;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, es;
    logic [4:0]  port_link_up, port_activity, port_full_duplex, port_collision, port_speed_100, straps;
    logic [4:0]  link_activity_led, duplex_collision_led_o, duplex_collision_led_oe, duplex_collision_led_i;
    logic [4:0]  port_speed_led;
    logic        cfg_mem_serial_in, cfg_mem_select_o, cfg_mem_select_oe, cfg_mem_serial_clock_o;
    logic        cfg_mem_serial_clock_oe, cfg_mem_serial_clock_i, cfg_mem_serial_out_o, cfg_mem_serial_out_oe;
    logic        cfg_mem_serial_out_i, backpressure_strap, autoneg_strap, crossover_strap, indicator_colour_strap;
    logic        chip_address_strap_high, chip_address_strap_low, strap_valid, reset_n_pin, err;
    logic [1:0]  v;
    logic [39:0] rows [4]; // status in, lamps out
    int          mismatches, checked, i, n;
    plsl_top #(.BLINK_HALF_CYCLES(HALF)) dut (.*);
    plsl_far_side #(.PATTERN(PAT)) far (.pclk(pclk), .strap_bits(straps), .dup_o(duplex_collision_led_o),
        .dup_oe(duplex_collision_led_oe), .sel_o(cfg_mem_select_o), .sel_oe(cfg_mem_select_oe),
        .clk_o(cfg_mem_serial_clock_o), .clk_oe(cfg_mem_serial_clock_oe), .dout_o(cfg_mem_serial_out_o),
        .dout_oe(cfg_mem_serial_out_oe), .dup_i(duplex_collision_led_i), .clk_i(cfg_mem_serial_clock_i),
        .dout_i(cfg_mem_serial_out_i), .din(cfg_mem_serial_in));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one apb transfer, then an idle cycle
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (k >= 16) begin
            mismatches++;
            summarize;
        end
    endtask
    // reset with given strap levels, release the rc input late
    task automatic boot(input logic [4:0] s, input logic tx);
        presetn <= 1'b0;
        rc_reset_input <= 1'b0;
        straps <= s;
        transmit_enable_pin <= tx;
        {port_link_up, port_activity, port_full_duplex, port_collision, port_speed_100} <= 25'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        chk(32'({duplex_collision_led_oe, cfg_mem_select_oe, cfg_mem_serial_clock_oe, cfg_mem_serial_out_oe,
            reset_n_pin, strap_valid}), 0);
        rc_reset_input <= 1'b1;
        for (n = 0; n < 16 && strap_valid !== 1'b1; n++)
            @(negedge pclk);
        chk(32'(strap_valid), 32'h1);
        if (n >= 16)
            summarize;
        chk(32'({duplex_collision_led_oe, cfg_mem_select_oe, cfg_mem_serial_clock_oe, cfg_mem_serial_out_oe,
            reset_n_pin}), 32'h1ff);
        @(posedge pclk);
        es = {23'h0, 1'b1, 2'b0, s[1], tx, s[4], s[3], s[0], s[2]};
        apb(1'b0, 12'h000, 32'h0);
        chk(q, es);
        chk(32'({chip_address_strap_high, chip_address_strap_low, indicator_colour_strap, crossover_strap,
            autoneg_strap, backpressure_strap}), 32'(es[5:0]));
    endtask
    initial begin
        {presetn, psel, penable, pwrite, rc_reset_input, transmit_enable_pin} = 6'h0;
        {paddr, pwdata, straps} = 49'h0;
        {port_link_up, port_activity, port_full_duplex, port_collision, port_speed_100} = 25'h0;
        mismatches = 0;
        checked = 0;
        rows[0] = {25'h0, 15'h7fff};
        rows[1] = {5'h1f, 5'h00, 5'h1f, 5'h00, 5'h1f, 15'h0};
        rows[2] = {5'h05, 5'h00, 5'h0a, 5'h00, 5'h11, 5'h1a, 5'h15, 5'h0e};
        rows[3] = {5'h1a, 5'h05, 5'h05, 5'h00, 5'h0e, 5'h05, 5'h1a, 5'h11};
        @(posedge pclk);
        boot(5'b10110, 1'b0);
        foreach (rows[r]) begin
            {port_link_up, port_activity, port_full_duplex, port_collision, port_speed_100} <= rows[r][39:15];
            repeat (3) @(posedge pclk);
            chk(32'({link_activity_led, duplex_collision_led_o, port_speed_led}), 32'(rows[r][14:0]));
        end
        // lamps-off blanks every lamp; clearing it brings row 3 back; status readback
        apb(1'b1, 12'h008, 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        chk(q, 32'h1);
        chk(32'({link_activity_led, duplex_collision_led_o, port_speed_led}), 32'h7fff);
        apb(1'b1, 12'h008, 32'h0);
        @(posedge pclk);
        chk(32'({link_activity_led, duplex_collision_led_o, port_speed_led}), 32'(rows[3][14:0]));
        apb(1'b0, 12'h00c, 32'h0);
        chk(q, {11'h0, rows[3][19:15], 3'h0, rows[3][29:25], 3'h0, rows[3][39:35]});
        // traffic on port 0, collisions on full-duplex port 1
        port_link_up <= 5'h01;
        port_activity <= 5'h01;
        port_full_duplex <= 5'h02;
        port_collision <= 5'h02;
        repeat (3) @(posedge pclk);
        for (i = 0; i < 2; i++) begin
            v = {link_activity_led[0], duplex_collision_led_o[1]};
            n = 0;
            do begin
                @(negedge pclk);
                n++;
            end while (link_activity_led[0] === v[1] && n < 40);
            if (n >= 40) begin
                mismatches++;
                summarize;
            end
            chk(32'(duplex_collision_led_o[1] ^ v[0]), 32'h1);
        end
        chk(n, 32'(HALF));
        @(posedge pclk);
        // bit-bang the memory: select and data out, then clock in bits
        apb(1'b1, 12'h004, 32'h5);
        chk(32'({cfg_mem_select_o, cfg_mem_serial_out_o, cfg_mem_serial_out_oe}), 32'h7);
        for (i = 0; i < 4; i++) begin
            apb(1'b0, 12'h004, 32'h0);
            chk(32'(q[8]), 32'(PAT[15-i]));
            apb(1'b1, 12'h004, 32'h3);
            chk(32'(cfg_mem_serial_clock_o), 32'h1);
            apb(1'b1, 12'h004, 32'h1);
        end
        apb(1'b1, 12'h004, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk(32'(q[8]), 32'h1);
        apb(1'b1, 12'h010, 32'hffffffff);
        chk(32'(err), 32'h1);
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        chk(q, es);
        boot(5'b01001, 1'b1);
        summarize;
    end
endmodule // tb_top
`default_nettype wire
